//--- verilog/sync_sram_pipelined_port.sv
// Synchronous late-write memory port core with AHB-Lite status registers
`timescale 1ns/1ps
// Function
// - Address, data and control are sampled only on the rising clock edge.
// - Pipelined mode holds read data one cycle in an output register.
// - Flow-through mode bypasses that register; data appears one cycle earlier.
// - Write data follows its command by two cycles pipelined, one flow-through.
// - Reads and writes may follow each other with no idle cycle.
// - Output enable high turns the data drivers off at once.
// - Writes start at the clock edge and complete without external pulses.
// - Each nine-bit lane has its own active-low write strobe.
// - Selected only with select one low, select two high, select three low.
// - Write select low means write, high means read.
// - Burst continue chooses between loading an address and advancing the counter.
// - The two low address bits preload the burst counter on a load.
// - Clock enable high freezes the port's command, burst, read and write state and data outputs; the register bus keeps running.
// - Sleep input high turns the drivers off at once; commands stop after two synchronising edges.
// - Burst order select low gives linear order, high interleaved.
// - Write data parity is checked with selectable even or odd sense.
module sync_sram_pipelined_port
  import sram_port_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [HIGH_W-1:0]   addrHigh,
  input  wire logic [BURST_W-1:0]  burst_start_bits,
  input  wire logic [DATA_W-1:0]   dataIn,
  output logic      [DATA_W-1:0]   dataOut,
  output logic                     dataOutEnable_n,
  input  wire logic                byte_strobe_lane0_n,
  input  wire logic                byte_strobe_lane1_n,
  input  wire logic                byte_strobe_lane2_n,
  input  wire logic                byte_strobe_lane3_n,
  input  wire logic                write_select_n,
  input  wire logic                chip_select_1_n,
  input  wire logic                chip_select_2,
  input  wire logic                chip_select_3_n,
  input  wire logic                burst_continue,
  input  wire logic                clock_enable_n,
  input  wire logic                out_enable_n,
  input  wire logic                sleep_request,
  input  wire logic                flow_thru_select_n,
  input  wire logic                linear_order_select_n,
  input  wire logic                hsel,
  input  wire logic [BUS_W-1:0]    haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [BUS_W-1:0]    hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic      [BUS_W-1:0]    hrdata,
  output logic                     hresp
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [DATA_W-1:0]   mem [0:DEPTH-1];

  logic [PIN_W-1:0]    pinMeta_reg;
  logic [PIN_W-1:0]    pinSync_reg;
  logic                sleepActive;
  logic                flowMode;
  logic                linearMode;
  logic                ce;

  op_t                 opNow;
  op_t                 lastOp_reg;
  op_t                 s1Op_reg;
  op_t                 s2Op_reg;
  op_t                 wrOp;
  logic                selected;
  logic [BURST_W-1:0]  beatNow;
  logic [BURST_W-1:0]  startNow;
  logic [HIGH_W-1:0]   highNow;
  logic [BURST_W-1:0]  burstLow;
  logic [ADDR_W-1:0]   curAddr;
  logic [LANES-1:0]    strobesNow_n;
  logic [BURST_W-1:0]  beat_reg;
  logic [BURST_W-1:0]  start_reg;
  logic [HIGH_W-1:0]   high_reg;
  logic [ADDR_W-1:0]   s1Addr_reg;
  logic [ADDR_W-1:0]   s2Addr_reg;
  logic [LANES-1:0]    s1Lanes_n_reg;
  logic [LANES-1:0]    s2Lanes_n_reg;

  logic [ADDR_W-1:0]   wrAddr;
  logic [LANES-1:0]    wrLanes_n;
  logic                wrNow;
  logic [DATA_W-1:0]   readWord;
  logic [DATA_W-1:0]   pipeData_reg;
  logic [DATA_W-1:0]   dataOut_reg;
  logic                dataOe_n_reg;
  logic                driveNext;

  logic [LANES-1:0]    laneHit;
  logic                ctrlOdd_reg;
  logic [LANES-1:0]    laneErr_reg;
  logic [ERRCNT_W-1:0] errCount_reg;

  logic                addrPhase;
  logic                mappedAddr;
  logic                busWrPend_reg;
  logic [DECODE_W-1:0] busAddr_reg;
  logic [BUS_W-1:0]    regRead;
  logic [BUS_W-1:0]    hrdata_reg;
  logic                hreadyout_reg;
  logic                hresp_reg;
  logic [LANES-1:0]    errClear;

  logic [ADDR_W-1:0]   probeAddr_reg;
  logic [DATA_W-1:0]   probeWord;
  logic [DATA_W-1:0]   oldWord;

  parity_if pif ();

  ////////////////////////////////////////////////////////////////////////////////
  // Asynchronous and strap pins

  // Straps and sleep come from outside the clock domain; burst order is
  // expected to sit at a fixed level, so a late change is only seen here.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta_reg <= PIN_RESET;
      pinSync_reg <= PIN_RESET;
    end else begin
      pinMeta_reg <= {linear_order_select_n, flow_thru_select_n, sleep_request};
      pinSync_reg <= pinMeta_reg;
    end
  end

  assign sleepActive = pinSync_reg[PIN_SLEEP];
  assign flowMode    = !pinSync_reg[PIN_FLOW];
  assign linearMode  = !pinSync_reg[PIN_LINEAR];
  assign ce          = !clock_enable_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode and burst counter

  assign selected     = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign strobesNow_n = {byte_strobe_lane3_n, byte_strobe_lane2_n,
                         byte_strobe_lane1_n, byte_strobe_lane0_n};

  always_comb begin
    if (!burst_continue) begin
      if (selected && !sleepActive) begin
        opNow = write_select_n ? OP_READ : OP_WRITE;
      end else begin
        opNow = OP_IDLE;
      end
      beatNow  = '0;
      startNow = burst_start_bits;
      highNow  = addrHigh;
    end else begin
      opNow    = sleepActive ? OP_IDLE : lastOp_reg;
      beatNow  = beat_reg + BEAT_ONE;
      startNow = start_reg;
      highNow  = high_reg;
    end
  end

  // Wraps inside a four-beat group in either order
  assign burstLow = linearMode ? (startNow + beatNow) : (startNow ^ beatNow);
  assign curAddr  = {highNow, burstLow};

  // Everything is sampled at the edge and only on enabled edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastOp_reg <= OP_IDLE;
      beat_reg   <= '0;
      start_reg  <= '0;
      high_reg   <= '0;
    end else if (ce) begin
      lastOp_reg <= opNow;
      beat_reg   <= beatNow;
      start_reg  <= startNow;
      high_reg   <= highNow;
    end
  end

  // Independent stages let read and write commands interleave freely
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1Op_reg      <= OP_IDLE;
      s2Op_reg      <= OP_IDLE;
      s1Addr_reg    <= '0;
      s2Addr_reg    <= '0;
      s1Lanes_n_reg <= '1;
      s2Lanes_n_reg <= '1;
    end else if (ce) begin
      s1Op_reg      <= opNow;
      s1Addr_reg    <= curAddr;
      s1Lanes_n_reg <= strobesNow_n;
      s2Op_reg      <= s1Op_reg;
      s2Addr_reg    <= s1Addr_reg;
      s2Lanes_n_reg <= s1Lanes_n_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Late write

  assign wrOp      = flowMode ? s1Op_reg : s2Op_reg;
  assign wrAddr    = flowMode ? s1Addr_reg : s2Addr_reg;
  assign wrLanes_n = flowMode ? s1Lanes_n_reg : s2Lanes_n_reg;
  assign wrNow     = ce && (wrOp == OP_WRITE);

  // Array is not reset: its contents are undefined at power-up
  always_ff @(posedge clk) begin
    if (wrNow) begin
      for (int l = 0; l < LANES; l++) begin
        if (!wrLanes_n[l]) begin
          mem[wrAddr][l*LANE_W +: LANE_W] <= dataIn[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path and drivers

  // No forwarding: a read issued before a pending late write to the same
  // word returns the old contents.
  assign readWord  = mem[curAddr];
  assign driveNext = flowMode ? (opNow == OP_READ) : (s1Op_reg == OP_READ);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pipeData_reg <= '0;
    end else if (ce) begin
      pipeData_reg <= readWord;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataOut_reg <= '0;
    end else if (ce) begin
      if (flowMode && opNow == OP_READ) begin
        dataOut_reg <= readWord;
      end else if (!flowMode && s1Op_reg == OP_READ) begin
        dataOut_reg <= pipeData_reg;
      end
    end
  end

  // Output enable and sleep force the drivers off without waiting for a clock
  always_ff @(posedge clk or posedge rst or posedge out_enable_n or posedge sleep_request) begin
    if (rst || out_enable_n || sleep_request) begin
      dataOe_n_reg <= 1'h1;
    end else if (ce) begin
      dataOe_n_reg <= !driveNext;
    end
  end

  assign dataOut         = dataOut_reg;
  assign dataOutEnable_n = dataOe_n_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Write parity

  assign pif.data     = dataIn;
  assign pif.oddSense = ctrlOdd_reg;
  assign laneHit      = pif.laneErr & ~wrLanes_n & {LANES{wrNow}};

  lane_parity_check parityCheck (
    .chk (pif.check)
  );

  // Set wins over a same-cycle clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      laneErr_reg <= '0;
    end else begin
      laneErr_reg <= (laneErr_reg & ~errClear) | laneHit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      errCount_reg <= '0;
    end else if (|laneHit && errCount_reg != ERRCNT_MAX) begin
      errCount_reg <= errCount_reg + ERRCNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave

  assign addrPhase  = hsel && htrans[HTRANS_ACT] && hready;
  assign mappedAddr = (haddr[BUS_W-1:DECODE_W] == '0);
  assign errClear   = (busWrPend_reg && busAddr_reg == REG_STATUS) ?
                      hwdata[STAT_ERR_LSB +: LANES] : '0;

  always_comb begin
    regRead = '0;
    case (haddr[DECODE_W-1:0])
      REG_CTRL: begin
        regRead[CTRL_ODD_BIT] = ctrlOdd_reg;
      end
      REG_STATUS: begin
        regRead[STAT_ERR_LSB +: LANES] = laneErr_reg;
        regRead[STAT_SLEEP_BIT]        = sleepActive;
        regRead[STAT_FLOW_BIT]         = flowMode;
        regRead[STAT_LINEAR_BIT]       = linearMode;
      end
      REG_ERRCNT: begin
        regRead[ERRCNT_W-1:0] = errCount_reg;
      end
      default: begin
        regRead = '0;
      end
    endcase
    if (!mappedAddr) begin
      regRead = '0;
    end
  end

  // Zero wait states: read data is prepared at the address phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busWrPend_reg <= 1'h0;
      busAddr_reg   <= '0;
      hrdata_reg    <= '0;
      hreadyout_reg <= 1'h1;
      hresp_reg     <= HRESP_OKAY;
    end else begin
      busWrPend_reg <= addrPhase && hwrite && mappedAddr && (hsize == HSIZE_WORD);
      busAddr_reg   <= haddr[DECODE_W-1:0];
      if (addrPhase && !hwrite) begin
        hrdata_reg <= regRead;
      end
      hreadyout_reg <= 1'h1;
      hresp_reg     <= HRESP_OKAY;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlOdd_reg <= CTRL_ODD_RESET;
    end else if (busWrPend_reg && busAddr_reg == REG_CTRL) begin
      ctrlOdd_reg <= hwdata[CTRL_ODD_BIT];
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      probeAddr_reg <= '0;
    end else begin
      probeAddr_reg <= wrAddr;
    end
  end

  assign probeWord = mem[probeAddr_reg];
  assign oldWord   = mem[wrAddr];

  AST_PIPE_READ: assert property (
    @(posedge clk) disable iff (rst)
    (ce && !flowMode && s1Op_reg == OP_READ) |=> (dataOut_reg == $past(pipeData_reg)))
    else $error("Pipelined read data not released from output register");

  AST_FLOW_READ: assert property (
    @(posedge clk) disable iff (rst)
    (ce && flowMode && opNow == OP_READ)
      |=> (dataOut_reg == $past(readWord)) && (!dataOe_n_reg || out_enable_n || sleep_request))
    else $error("Flow-through read data not on the pins after one edge");

  AST_PIPE_WRITE_LAG: assert property (
    @(posedge clk) disable iff (rst)
    (ce && !flowMode && opNow == OP_WRITE) ##1 (ce && !flowMode) ##1 (ce && !flowMode)
      |-> wrNow)
    else $error("Pipelined write data not taken two enabled edges after command");

  AST_FLOW_WRITE_LAG: assert property (
    @(posedge clk) disable iff (rst)
    (ce && flowMode && opNow == OP_WRITE) ##1 (ce && flowMode) |-> wrNow)
    else $error("Flow-through write data not taken one edge after command");

  AST_OE_OVERRIDE: assert property (
    @(posedge clk) disable iff (rst)
    (out_enable_n || sleep_request) |-> dataOe_n_reg)
    else $error("Drivers on while output enable or sleep is high");

  AST_LANE_WRITTEN: assert property (
    @(posedge clk) disable iff (rst)
    (wrNow && !wrLanes_n[1]) |=> (probeWord[LANE_W +: LANE_W] == $past(dataIn[LANE_W +: LANE_W])))
    else $error("Strobed lane not written");

  AST_LANE_KEPT: assert property (
    @(posedge clk) disable iff (rst)
    (wrNow && wrLanes_n[0]) |=> (probeWord[LANE_W-1:0] == $past(oldWord[LANE_W-1:0])))
    else $error("Unstrobed lane changed by a write");

  AST_DESELECT: assert property (
    @(posedge clk) disable iff (rst)
    (!burst_continue && !selected) |-> (opNow == OP_IDLE))
    else $error("Command accepted while not selected");

  AST_WRITE_SELECT: assert property (
    @(posedge clk) disable iff (rst)
    (ce && !burst_continue && selected && !sleepActive)
      |-> (opNow == (write_select_n ? OP_READ : OP_WRITE)) ##1 (s1Op_reg == $past(opNow)))
    else $error("Write select decoded wrongly");

  AST_LOAD_START: assert property (
    @(posedge clk) disable iff (rst)
    (ce && !burst_continue) |=> (beat_reg == '0 && start_reg == $past(burst_start_bits)))
    else $error("Burst counter not preloaded on load");

  AST_ADVANCE: assert property (
    @(posedge clk) disable iff (rst)
    (ce && burst_continue) |=> (beat_reg == BURST_W'($past(beat_reg) + BEAT_ONE)))
    else $error("Burst counter did not advance by one");

  AST_INTERLEAVE: assert property (
    @(posedge clk) disable iff (rst)
    (burst_continue && !linearMode) |-> (burstLow == (start_reg ^ BURST_W'(beat_reg + BEAT_ONE))))
    else $error("Interleaved burst address wrong");

  AST_FREEZE: assert property (
    @(posedge clk) disable iff (rst)
    (clock_enable_n && !out_enable_n && !sleep_request)
      |=> $stable(s1Op_reg) && $stable(dataOut_reg) && $stable(beat_reg) && $stable(dataOe_n_reg))
    else $error("State changed on a disabled clock edge");

  AST_PARITY_FLAG: assert property (
    @(posedge clk) disable iff (rst)
    (wrNow && !wrLanes_n[0] && ((^dataIn[LANE_W-1:0]) != ctrlOdd_reg)) |=> laneErr_reg[0])
    else $error("Parity error on lane not flagged");

endmodule // sync_sram_pipelined_port

//--- verilog/sram_port_pkg.sv
// Shared constants and types for the synchronous late-write memory port
package sram_port_pkg;

  localparam int LANES    = 4;
  localparam int LANE_W   = 9;
  localparam int DATA_W   = LANES * LANE_W;
  localparam int BURST_W  = 2;
  localparam int HIGH_W   = 16;
  localparam int ADDR_W   = HIGH_W + BURST_W;
  localparam int DEPTH    = 1 << ADDR_W;
  localparam int PIN_W    = 3;

  // Synchronised pin positions and their values after reset
  localparam int PIN_SLEEP  = 0;
  localparam int PIN_FLOW   = 1;
  localparam int PIN_LINEAR = 2;
  localparam logic [PIN_W-1:0] PIN_RESET = 3'h6;

  // Register bus
  localparam int BUS_W      = 32;
  localparam int DECODE_W   = 8;
  localparam int HTRANS_ACT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY       = 1'h0;

  localparam logic [DECODE_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [DECODE_W-1:0] REG_STATUS = 8'h04;
  localparam logic [DECODE_W-1:0] REG_ERRCNT = 8'h08;

  localparam int CTRL_ODD_BIT    = 0;
  localparam int STAT_ERR_LSB    = 0;
  localparam int STAT_SLEEP_BIT  = 4;
  localparam int STAT_FLOW_BIT   = 5;
  localparam int STAT_LINEAR_BIT = 6;
  localparam int ERRCNT_W        = 16;

  localparam logic                CTRL_ODD_RESET = 1'h0;
  localparam logic [ERRCNT_W-1:0] ERRCNT_MAX     = 16'hffff;
  localparam logic [ERRCNT_W-1:0] ERRCNT_ONE     = 16'h0001;
  localparam logic [BURST_W-1:0]  BEAT_ONE       = 2'h1;

  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_t;

endpackage

//--- verilog/parity_if.sv
// Carrier between the port core and its lane parity checker
`timescale 1ns/1ps
interface parity_if;
  import sram_port_pkg::*;
  logic [DATA_W-1:0] data;
  logic              oddSense;
  logic [LANES-1:0]  laneErr;
  modport check (input data, input oddSense, output laneErr);
  modport feed  (output data, output oddSense, input laneErr);
endinterface

//--- verilog/lane_parity_check.sv
// Per-lane parity checker for incoming write data
`timescale 1ns/1ps
module lane_parity_check
  import sram_port_pkg::*;
(
  parity_if.check chk
);

  // Each lane is eight data bits plus one parity bit
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      chk.laneErr[l] = ((^chk.data[l*LANE_W +: LANE_W]) != chk.oddSense);
    end
  end

endmodule // lane_parity_check

//--- sim/mem_ctrl_model.sv
// Controller model that drives the memory port's command and data pins
`timescale 1ns/1ps
module mem_ctrl_model
  import sram_port_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [DATA_W-1:0]   dataOut,
  input  wire logic                dataOutEnable_n,
  output logic      [ADDR_W-1:0]   addr,
  output logic      [DATA_W-1:0]   dataIn,
  output logic      [LANES-1:0]    strobe_n,
  output logic                     writeSel_n,
  output logic      [2:0]          chipSel,
  output logic                     burstCont,
  output logic                     clkEnable_n
);
  initial begin
    addr = '0;
    dataIn = '0;
    strobe_n = '1;
    writeSel_n = 1'b1;
    chipSel = 3'h1;
    burstCont = 1'b0;
    clkEnable_n = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command n lands on edge n; its data slot and read sample come lat edges later
  task automatic memOp(input int beats, input logic [3:0] wr, input logic [3:0] ld,
                       input logic [3:0][ADDR_W-1:0] a, input logic [3:0][DATA_W-1:0] wd,
                       input logic [LANES-1:0] strb, input int lat, input int stallAt,
                       input int desel, output logic [3:0][DATA_W-1:0] rd);
    int k;
    rd = '1;
    @(posedge clk);
    for (int n = 0; n < beats + lat; n++) begin
      if (n == stallAt) begin
        clkEnable_n <= 1'b1;
        @(posedge clk);
      end
      clkEnable_n <= 1'b0;
      k = n - lat;
      if (n < beats) begin
        burstCont  <= !ld[n];
        writeSel_n <= !wr[n];
        addr       <= ld[n] ? a[n] : ~addr;
        strobe_n   <= strb;
        chipSel    <= {desel == 3, desel != 2, desel == 1};
      end else begin
        burstCont  <= 1'b0;
        chipSel    <= 3'h1;
        addr       <= ~addr;
      end
      // Outside its slot the data bus toggles so stale data never looks valid
      if (k >= 0 && k < beats && wr[k])
        dataIn <= wd[k];
      else
        dataIn <= ~dataIn;
      @(negedge clk);
      if (k >= 0 && k < beats && !wr[k])
        rd[k] = (dataOutEnable_n === 1'b0) ? dataOut : '1;
      @(posedge clk);
    end
    dataIn <= ~dataIn;
  endtask
endmodule // mem_ctrl_model

//--- sim/sync_sram_pipelined_port_tb.sv
// Self-checking bench for the memory port and its status registers
`timescale 1ns/1ps
module sync_sram_pipelined_port_tb
  import sram_port_pkg::*;
;
  logic                   clk, rst, writeSel_n, burstCont, clkEnable_n, dataOutEnable_n;
  logic                   outEnable_n, sleepReq, flowSel_n, linearSel_n, oddSense;
  logic                   hsel, hwrite, hreadyout, hresp;
  logic [ADDR_W-1:0]      addr;
  logic [DATA_W-1:0]      dataIn, dataOut;
  logic [LANES-1:0]       strobe_n;
  logic [2:0]             chipSel, hsize;
  logic [1:0]             htrans;
  logic [BUS_W-1:0]       haddr, hwdata, hrdata, stBase;
  logic [3:0][DATA_W-1:0] rdq;
  logic [DATA_W-1:0]      mem [logic [ADDR_W-1:0]];
  int                     mismatches, comparisons, lat;

  sync_sram_pipelined_port dut_u (
    .clk(clk), .rst(rst), .addrHigh(addr[ADDR_W-1:BURST_W]),
    .burst_start_bits(addr[BURST_W-1:0]), .dataIn(dataIn), .dataOut(dataOut),
    .dataOutEnable_n(dataOutEnable_n), .byte_strobe_lane0_n(strobe_n[0]),
    .byte_strobe_lane1_n(strobe_n[1]), .byte_strobe_lane2_n(strobe_n[2]),
    .byte_strobe_lane3_n(strobe_n[3]), .write_select_n(writeSel_n),
    .chip_select_1_n(chipSel[0]), .chip_select_2(chipSel[1]), .chip_select_3_n(chipSel[2]),
    .burst_continue(burstCont), .clock_enable_n(clkEnable_n), .out_enable_n(outEnable_n),
    .sleep_request(sleepReq), .flow_thru_select_n(flowSel_n),
    .linear_order_select_n(linearSel_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  mem_ctrl_model ctrl_u (
    .clk(clk), .dataOut(dataOut), .dataOutEnable_n(dataOutEnable_n), .addr(addr),
    .dataIn(dataIn), .strobe_n(strobe_n), .writeSel_n(writeSel_n), .chipSel(chipSel),
    .burstCont(burstCont), .clkEnable_n(clkEnable_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmpWord(input string what, input logic [DATA_W-1:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmpReg(input string what, input logic [BUS_W-1:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic ahb(input logic wr, input logic [DECODE_W-1:0] a,
                     input logic [BUS_W-1:0] wd, output logic [BUS_W-1:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {{(BUS_W-DECODE_W){1'b0}}, a};
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    cmpReg("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic regIs(input logic [DECODE_W-1:0] a, input logic [BUS_W-1:0] exp);
    logic [BUS_W-1:0] r;
    ahb(1'b0, a, '0, r);
    cmpReg("register", exp, r);
  endtask

  task automatic regW(input logic [DECODE_W-1:0] a, input logic [BUS_W-1:0] d);
    logic [BUS_W-1:0] r;
    ahb(1'b1, a, d, r);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Straps only move under reset, as a board would tie them
  task automatic doReset(input logic flowN, input logic linN);
    @(posedge clk);
    rst         <= 1'b1;
    flowSel_n   <= flowN;
    linearSel_n <= linN;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    lat    = flowN ? 2 : 1;
    stBase = {25'h0, !linN, !flowN, 5'h0};
  endtask

  function automatic logic [DATA_W-1:0] mk(input logic [DATA_W-1:0] x, input int bad);
    mk = x;
    for (int l = 0; l < LANES; l++)
      mk[l*LANE_W+8] = ^x[l*LANE_W+:8] ^ oddSense ^ (l == bad);
  endfunction

  function automatic logic [ADDR_W-1:0] baddr(input logic [ADDR_W-1:0] a, input int k);
    logic [1:0] b;
    b = linearSel_n ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
    return {a[ADDR_W-1:2], b};
  endfunction

  task automatic wr1(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [LANES-1:0] strb, input int desel, input bit upd);
    ctrl_u.memOp(1, 4'h1, 4'h1, {4{a}}, {4{d}}, strb, lat, -1, desel, rdq);
    for (int l = 0; l < LANES; l++)
      if (upd && !strb[l])
        mem[a][l*LANE_W+:LANE_W] = d[l*LANE_W+:LANE_W];
  endtask

  task automatic rd1(input logic [ADDR_W-1:0] a);
    ctrl_u.memOp(1, 4'h0, 4'h1, {4{a}}, '0, 4'hf, lat, -1, 0, rdq);
    cmpWord("read", mem[a], rdq[0]);
  endtask

  task automatic burst(input logic wr, input logic [ADDR_W-1:0] a, input int stallAt);
    logic [3:0][DATA_W-1:0] wd;
    for (int k = 0; k < 4; k++)
      wd[k] = mk({a, 6'h0, k[11:0]}, -1);
    ctrl_u.memOp(4, {4{wr}}, 4'h1, {4{a}}, wd, 4'h0, lat, stallAt, 0, rdq);
    for (int k = 0; k < 4; k++)
      if (wr)
        mem[baddr(a, k)] = wd[k];
      else
        cmpWord("burst read", mem[baddr(a, k)], rdq[k]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    outEnable_n = 1'b0;
    sleepReq = 1'b0;
    flowSel_n = 1'b1;
    linearSel_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = '0;
    oddSense = 1'b0;
    mismatches = 0;
    comparisons = 0;
    doReset(1'b1, 1'b0);
    regIs(REG_CTRL, 32'h0);
    regIs(REG_STATUS, stBase);
    regIs(REG_ERRCNT, 32'h0);
    regW(REG_CTRL, 32'h1);
    regW(8'h10, 32'h0);
    regIs(REG_CTRL, 32'h1);
    regIs(8'h0c, 32'h0);
    regW(REG_CTRL, 32'h0);
    $display("test registers done");
    wr1(18'h00100, mk(36'h1_2345_6789, -1), 4'h0, 0, 1);
    rd1(18'h00100);
    wr1(18'h00100, mk(36'h0_abcd_ef01, -1), 4'h5, 0, 1);
    rd1(18'h00100);
    wr1(18'h00300, mk(36'h0_3333_0303, -1), 4'h0, 0, 1);
    // Read, write, read with no gap: the write may not disturb either read
    ctrl_u.memOp(3, 4'h2, 4'h7, {18'h0, 18'h00300, 18'h00200, 18'h00100},
                 {4{mk(36'h0_2222_0202, -1)}}, 4'h0, lat, -1, 0, rdq);
    cmpWord("read before write", mem[18'h00100], rdq[0]);
    cmpWord("read after write", mem[18'h00300], rdq[2]);
    mem[18'h00200] = mk(36'h0_2222_0202, -1);
    rd1(18'h00200);
    $display("test pipelined done");
    burst(1'b1, 18'h00402, -1);
    for (int k = 0; k < 4; k++)
      rd1(baddr(18'h00402, k));
    burst(1'b0, 18'h00402, 2);
    for (int s = 1; s < 4; s++)
      wr1(18'h00100, mk(36'h0_0f0f_0f0f, -1), 4'h0, s, 0);
    rd1(18'h00100);
    outEnable_n <= 1'b1;
    ctrl_u.memOp(1, 4'h0, 4'h1, {4{18'h00100}}, '0, 4'hf, lat, -1, 0, rdq);
    cmpWord("drivers off", '1, rdq[0]);
    outEnable_n <= 1'b0;
    $display("test burst and select done");
    sleepReq <= 1'b1;
    repeat (4) @(posedge clk);
    cmpReg("sleep drivers", 32'h1, {31'h0, dataOutEnable_n});
    regIs(REG_STATUS, stBase | 32'h10);
    wr1(18'h00100, mk(36'h0_7777_1111, -1), 4'h0, 0, 0);
    sleepReq <= 1'b0;
    repeat (4) @(posedge clk);
    rd1(18'h00100);
    $display("test sleep done");
    wr1(18'h00500, mk(36'h0_1357_9bdf, 0), 4'h0, 0, 0);
    regIs(REG_STATUS, stBase | 32'h1);
    regIs(REG_ERRCNT, 32'h1);
    regW(REG_STATUS, 32'hf);
    regIs(REG_STATUS, stBase);
    regW(REG_CTRL, 32'h1);
    oddSense = 1'b1;
    wr1(18'h00500, mk(36'h0_2468_ace0, 1), 4'h2, 0, 0);
    wr1(18'h00500, mk(36'h0_2468_ace0, 3), 4'h0, 0, 0);
    regIs(REG_STATUS, stBase | 32'h8);
    regIs(REG_ERRCNT, 32'h2);
    oddSense = 1'b0;
    $display("test parity done");
    doReset(1'b0, 1'b1);
    regIs(REG_STATUS, stBase);
    rd1(18'h00100);
    burst(1'b1, 18'h00601, -1);
    for (int k = 0; k < 4; k++)
      rd1(baddr(18'h00601, k));
    burst(1'b0, 18'h00601, 1);
    wr1(18'h00700, mk(36'h0_4141_1414, -1), 4'h0, 0, 1);
    rd1(18'h00700);
    $display("test flow-through done");
    finish_test();
  end
endmodule // sync_sram_pipelined_port_tb
